/* File: rtl/tcs_pkg.sv */
package tcs_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, low address byte decoded)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CSC        = 8'h00;
    localparam logic [7:0] ADDR_CTRL       = 8'h04;
    localparam logic [7:0] ADDR_VALUE      = 8'h08;
    localparam logic [7:0] ADDR_COUNT      = 8'h0c;
    localparam logic [7:0] ADDR_MODULO     = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CSC_FLAG_BIT   = 7;
    localparam int CSC_IE_BIT     = 6;
    localparam int CSC_MSH_BIT    = 5;
    localparam int CSC_MSL_BIT    = 4;
    localparam int CSC_ELS_HI     = 3;
    localparam int CSC_ELS_LO     = 2;
    localparam int CTRL_CENTER_PWM_SELECT_BIT = 0;
    localparam int CTRL_RUN_BIT   = 1;
    localparam int IRQ_EVENT_BIT  = 0;
    localparam int IRQ_WRAP_BIT   = 1;

    // ------------------------------------------------------------
    // widths, codes and reset values
    // ------------------------------------------------------------
    localparam int          CNT_W          = 16;
    localparam logic [1:0]  ELS_RELEASED   = 2'h0;
    localparam logic [1:0]  ELS_CAP_RISE   = 2'h1;
    localparam logic [1:0]  ELS_CAP_FALL   = 2'h2;
    localparam logic [1:0]  ELS_OC_TOGGLE  = 2'h1;
    localparam logic [1:0]  ELS_OC_CLEAR   = 2'h2;
    localparam logic [1:0]  ELS_RESET      = 2'h0;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] VALUE_RESET    = 16'h0000;
    localparam logic [15:0] MODULO_RESET   = 16'hffff;
    localparam logic [1:0]  IRQ_RESET      = 2'h0;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

    typedef enum logic [3:0] {
        MODE_CAPTURE    = 4'b0001,
        MODE_COMPARE    = 4'b0010,
        MODE_EDGE_PWM   = 4'b0100,
        MODE_CENTER_PWM = 4'b1000
    } tcs_mode_e;

    typedef enum logic [3:0] {
        DP_IDLE      = 4'b0001,
        DP_WRITE     = 4'b0010,
        DP_READ_WAIT = 4'b0100,
        DP_READ_DONE = 4'b1000
    } tcs_dp_e;

endpackage

/* File: rtl/tcs_channel.sv */
// Notes on behaviour
// - capture mode: active pin edge sets the channel event flag.
// - compare or edge pwm: counter equal to channel value sets the flag.
// - center pwm: every counter match with channel value sets the flag.
// - channel interrupt request while flag set and interrupt enable is 1.
// - flag clears only on read while set, then write of 0.
// - new event before clear write restarts the sequence; flag stays set.
// - reset clears flag; writing 1 to flag has no effect.
// - interrupt enable is read/write bit 6, cleared by reset.
// - center select 0 and mode high bit 1 selects edge pwm.
// - center select 0, mode high 0: mode low bit picks capture/compare.
// - edge/level field picks capture edge, compare action or pwm polarity.
// - edge/level field 0 releases the pin; no drive, no sensing.
// - released pin: compare matching and flag setting still work.
`timescale 1ns/1ns
`default_nettype none
module tcs_channel
    import tcs_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ch_pin_in,
    output logic             ch_pin_out,
    output logic             ch_pin_oe,
    output logic             chan_irq,
    output logic             irq
);

    // ------------------------------------------------------------
    // bus data phase
    // ------------------------------------------------------------
    tcs_dp_e     dp_state;
    tcs_dp_e     next_dp_state;
    logic [7:0]  dp_addr;
    logic        accept;
    logic        wr_csc;
    logic        rd_csc;
    logic        rd_status;
    logic        wr_en;
    logic [31:0] rd_mux;

    // channel state
    logic              flag;
    logic              armed;
    logic              ie;
    logic              msh;
    logic              msl;
    logic [1:0]        els;
    logic              center_pwm_select;
    logic              run;
    logic [CNT_W-1:0]  value;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  modulo;
    logic              count_down;
    logic [1:0]        irq_status;
    logic [1:0]        irq_mask;
    tcs_mode_e         mode;
    logic              pin_s1;
    logic              pin_s2;
    logic              pin_s3;
    logic              cap_evt;
    logic              match_evt;
    logic              ch_event;
    logic              wrap_evt;
    logic              pwm_level;

    assign accept = hsel && htrans[1] && hready;
    assign hresp  = 1'b0;
    assign hreadyout = (dp_state != DP_READ_WAIT);
    assign wr_en     = (dp_state == DP_WRITE);
    assign wr_csc    = wr_en && (dp_addr == ADDR_CSC);
    assign rd_csc    = (dp_state == DP_READ_WAIT) && (dp_addr == ADDR_CSC);
    assign rd_status = (dp_state == DP_READ_WAIT) && (dp_addr == ADDR_IRQ_STATUS);

    always_comb
    begin
        case (dp_state)
            DP_READ_WAIT: next_dp_state = DP_READ_DONE;
            default:
            begin
                if (accept)
                    next_dp_state = hwrite ? DP_WRITE : DP_READ_WAIT;
                else
                    next_dp_state = DP_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_state <= DP_IDLE;
            dp_addr  <= 8'h00;
        end
        else
        begin
            dp_state <= next_dp_state;
            if (accept)
                dp_addr <= haddr[7:0];
        end
    end

    // read data is latched in the wait cycle, so a write just before is seen
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (dp_addr == ADDR_CSC)
            rd_mux = {24'h000000, flag, ie, msh, msl, els, 2'b00};
        else if (dp_addr == ADDR_CTRL)
            rd_mux = {30'h00000000, run, center_pwm_select};
        else if (dp_addr == ADDR_VALUE)
            rd_mux = {16'h0000, value};
        else if (dp_addr == ADDR_COUNT)
            rd_mux = {16'h0000, count};
        else if (dp_addr == ADDR_MODULO)
            rd_mux = {16'h0000, modulo};
        else if (dp_addr == ADDR_IRQ_STATUS)
            rd_mux = {30'h00000000, irq_status};
        else if (dp_addr == ADDR_IRQ_MASK)
            rd_mux = {30'h00000000, irq_mask};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= RDATA_RESET;
        else if (dp_state == DP_READ_WAIT)
            hrdata <= rd_mux;
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ie       <= 1'b0;
            msh      <= 1'b0;
            msl      <= 1'b0;
            els      <= ELS_RESET;
            center_pwm_select    <= 1'b0;
            run      <= 1'b0;
            modulo   <= MODULO_RESET;
            irq_mask <= IRQ_RESET;
        end
        else if (wr_en)
        begin
            if (dp_addr == ADDR_CSC)
            begin
                ie  <= hwdata[CSC_IE_BIT];
                msh <= hwdata[CSC_MSH_BIT];
                msl <= hwdata[CSC_MSL_BIT];
                els <= hwdata[CSC_ELS_HI:CSC_ELS_LO];
            end
            else if (dp_addr == ADDR_CTRL)
            begin
                center_pwm_select <= hwdata[CTRL_CENTER_PWM_SELECT_BIT];
                run   <= hwdata[CTRL_RUN_BIT];
            end
            else if (dp_addr == ADDR_MODULO)
                modulo <= hwdata[CNT_W-1:0];
            else if (dp_addr == ADDR_IRQ_MASK)
                irq_mask <= hwdata[1:0];
        end
    end

    always_comb
    begin
        if (center_pwm_select)
            mode = MODE_CENTER_PWM;
        else if (msh)
            mode = MODE_EDGE_PWM;
        else if (msl)
            mode = MODE_COMPARE;
        else
            mode = MODE_CAPTURE;
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count      <= COUNT_RESET;
            count_down <= 1'b0;
        end
        else if (run)
        begin
            if (modulo == COUNT_RESET)
            begin
                count      <= COUNT_RESET;
                count_down <= 1'b0;
            end
            else if (mode != MODE_CENTER_PWM)
            begin
                count_down <= 1'b0;
                count      <= (count >= modulo) ? COUNT_RESET : count + 16'h0001;
            end
            else if (!count_down && count >= modulo)
            begin
                count_down <= 1'b1;
                count      <= count - 16'h0001;
            end
            else if (count_down && count == COUNT_RESET)
            begin
                count_down <= 1'b0;
                count      <= count + 16'h0001;
            end
            else
                count <= count_down ? count - 16'h0001 : count + 16'h0001;
        end
    end

    assign wrap_evt = run && ((mode == MODE_CENTER_PWM) ? (count_down && count == COUNT_RESET)
                                                        : (count >= modulo));

    // ------------------------------------------------------------
    // channel events
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end
        else
        begin
            pin_s1 <= ch_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign cap_evt = (mode == MODE_CAPTURE) && (els != ELS_RELEASED)
                   && ((els != ELS_CAP_FALL && pin_s2 && !pin_s3)
                   ||  (els != ELS_CAP_RISE && !pin_s2 && pin_s3));
    // match in compare, edge pwm or center pwm
    assign match_evt = run && (mode != MODE_CAPTURE) && (count == value);
    assign ch_event  = cap_evt || match_evt;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            value <= VALUE_RESET;
        else if (cap_evt)
            value <= count;
        else if (wr_en && dp_addr == ADDR_VALUE)
            value <= hwdata[CNT_W-1:0];
    end

    // write of 1 leaves flag alone
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flag <= 1'b0;
        else if (ch_event)
            flag <= 1'b1;
        else if (wr_csc && armed && !hwdata[CSC_FLAG_BIT])
            flag <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            armed <= 1'b0;
        else if (ch_event)
            armed <= 1'b0;
        else if (rd_csc && flag)
            armed <= 1'b1;
        else if (wr_csc)
            armed <= 1'b0;
    end

    assign chan_irq = flag && ie;

    // ------------------------------------------------------------
    // interrupt status, read clears, set wins
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_status <= IRQ_RESET;
        else
        begin
            irq_status[IRQ_EVENT_BIT] <= ch_event || (irq_status[IRQ_EVENT_BIT] && !rd_status);
            irq_status[IRQ_WRAP_BIT]  <= wrap_evt || (irq_status[IRQ_WRAP_BIT] && !rd_status);
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // polarity, low-true when low bit set
    assign pwm_level = (count < value) ^ els[0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ch_pin_out <= 1'b0;
        else if (mode == MODE_EDGE_PWM || mode == MODE_CENTER_PWM)
            ch_pin_out <= pwm_level;
        else if (mode == MODE_COMPARE && match_evt)
        begin
            if (els == ELS_OC_TOGGLE)
                ch_pin_out <= !ch_pin_out;
            else if (els == ELS_OC_CLEAR)
                ch_pin_out <= 1'b0;
            else
                ch_pin_out <= 1'b1;
        end
    end

    // pin released when field is zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ch_pin_oe <= 1'b0;
        else
            ch_pin_oe <= (els != ELS_RELEASED) && (mode != MODE_CAPTURE);
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_capture_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        cap_evt |=> flag && irq_status[IRQ_EVENT_BIT])
        else $error("capture edge did not set flag");
    a_match_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (run && mode != MODE_CAPTURE && mode != MODE_CENTER_PWM && count == value) |=> flag)
        else $error("compare match did not set flag");
    a_center_match_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (run && mode == MODE_CENTER_PWM && count == value) |=> flag)
        else $error("center pwm match did not set flag");
    a_irq_request: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(flag) && ie) |-> chan_irq)
        else $error("channel irq missing");
    a_clear_sequence: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(flag) |-> $past(wr_csc) && $past(armed) && !$past(hwdata[CSC_FLAG_BIT]))
        else $error("flag cleared without read then write 0");
    a_event_restarts: assert property (@(posedge hclk) disable iff (!hresetn)
        (ch_event && wr_csc) |=> flag && !armed)
        else $error("event lost by clear write");
    a_write_one_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_csc && flag && hwdata[CSC_FLAG_BIT]) |=> flag)
        else $error("writing 1 cleared flag");
    a_ie_writable: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_csc |=> ie == $past(hwdata[CSC_IE_BIT]))
        else $error("interrupt enable not written");
    a_edge_pwm_mode: assert property (@(posedge hclk) disable iff (!hresetn)
        (!center_pwm_select && msh) |-> mode == MODE_EDGE_PWM)
        else $error("edge pwm mode not selected");
    a_pin_released: assert property (@(posedge hclk) disable iff (!hresetn)
        (els == ELS_RELEASED) [*2] |-> !ch_pin_oe)
        else $error("released pin still driven");
    a_capture_value: assert property (@(posedge hclk) disable iff (!hresetn)
        cap_evt |=> value == $past(count))
        else $error("capture did not copy counter");

endmodule
`default_nettype wire

/* File: verification/tcs_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module tcs_pin_model
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ch_pin_out,
    input  wire logic ch_pin_oe,
    input  wire logic drive_level,
    output logic      pin_level,
    output int        toggles
);
    logic last;

    // released pin
    // the source drives the line whenever the channel lets go of it
    assign pin_level = ch_pin_oe ? ch_pin_out : drive_level;

    // compare pin action
    // a load that counts every level change the channel puts on the pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            last    <= 1'b0;
            toggles <= 0;
        end
        else
        begin
            last <= pin_level;
            if (ch_pin_oe && pin_level != last)
                toggles <= toggles + 1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb
    import tcs_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, drive_level;
    logic [31:0] haddr, hwdata, hrdata, rd, rng, c, v;
    logic [1:0]  htrans;
    logic        hreadyout, hresp, ch_pin_out, ch_pin_oe, chan_irq, irq, pin_level;
    logic [4:0]  m;
    int          toggles, t, miscompares, total_checks;

    tcs_channel u_tcs_channel (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ch_pin_in(pin_level),
        .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .chan_irq(chan_irq), .irq(irq));

    tcs_pin_model u_tcs_pin_model (.hclk(hclk), .hresetn(hresetn), .ch_pin_out(ch_pin_out),
        .ch_pin_oe(ch_pin_oe), .drive_level(drive_level), .pin_level(pin_level),
        .toggles(toggles));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] csc(input logic f, ie, msh, msl, input logic [1:0] els);
        return {24'h0, f, ie, msh, msl, els, 2'b00};
    endfunction

    // pwm pin level: high while counter is below channel value, inverted when low-true
    function automatic logic [31:0] pwm_exp(input logic [15:0] cnt, val, input logic lo);
        return {31'h0, (cnt < val) ^ lo};
    endfunction

    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // waits for hready seen high at a falling edge, takes data there, then steps to the rising edge
    task wait_rdy;
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            n++;
            @(negedge hclk);
        end
        if (n >= 50)
            miscompares++;
        rd = hrdata;
        @(posedge hclk);
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        ahb(1'b0, a, 32'h0);
        check(nm, e, rd);
    endtask

    task clear_flag(input logic [31:0] v);
        ahb(1'b0, ADDR_CSC, 32'h0);
        ahb(1'b1, ADDR_CSC, v);
    endtask

    task set_pin(input logic v);
        @(posedge hclk);
        drive_level <= v;
        repeat (6) @(posedge hclk);
    endtask

    task poll_flag;
        rd = 32'h0;
        for (int i = 0; i < 40 && rd[7] !== 1'b1; i++)
            ahb(1'b0, ADDR_CSC, 32'h0);
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial
    begin
        #200000;
        miscompares++;
        close_out;
    end

    initial
    begin
        hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; drive_level = 1'b0;
        haddr = 32'h0; hwdata = 32'h0; htrans = 2'b00; rng = 32'h8159;
        miscompares = 0; total_checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(ADDR_CSC, 32'h0, "csc reset");
        rchk(ADDR_MODULO, 32'h0000ffff, "modulo reset");
        rchk(ADDR_IRQ_STATUS, 32'h0, "status reset");
        rchk(8'h40, 32'h0, "unmapped");
        check("irq reset", 32'h0, {chan_irq, irq});
        check("hresp", 32'h0, hresp);
        $display("test reset done");
        // capture: every edge select code, rising then falling pin edge
        rng = xs(rng) | 32'h1;
        ahb(1'b1, ADDR_VALUE, rng);
        rchk(ADDR_VALUE, {16'h0, rng[15:0]}, "value rw");
        ahb(1'b1, ADDR_IRQ_MASK, 32'h1);
        for (int e = 0; e < 4; e++)
        begin
            c = csc(1'b0, 1'b1, 1'b0, 1'b0, e[1:0]);
            ahb(1'b1, ADDR_CSC, c);
            set_pin(1'b1);
            rchk(ADDR_CSC, c | {e[0], 7'h0}, "rise flag");
            if (e == 1)
            begin
                check("chan irq", 32'h1, chan_irq);
                check("irq on", 32'h1, irq);
                rchk(ADDR_IRQ_STATUS, 32'h1, "status");
                check("irq off", 32'h0, irq);
            end
            clear_flag(c);
            set_pin(1'b0);
            rchk(ADDR_CSC, c | {e[1], 7'h0}, "fall flag");
            clear_flag(c);
            check("cap oe", 32'h0, ch_pin_oe);
        end
        rchk(ADDR_VALUE, 32'h0, "captured");
        ahb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        ahb(1'b1, ADDR_IRQ_MASK, 32'h0);
        $display("test capture done");
        // clear sequence corners
        c = csc(1'b0, 1'b1, 1'b0, 1'b0, 2'h1);
        set_pin(1'b1);
        ahb(1'b0, ADDR_CSC, 32'h0);
        ahb(1'b1, ADDR_CSC, c | 32'h80);
        ahb(1'b1, ADDR_CSC, c);
        rchk(ADDR_CSC, c | 32'h80, "no clear");
        check("masked", 32'h2, {chan_irq, irq});
        set_pin(1'b0);
        set_pin(1'b1);
        ahb(1'b1, ADDR_CSC, c);
        rchk(ADDR_CSC, c | 32'h80, "restart");
        clear_flag(c);
        rchk(ADDR_CSC, c, "cleared");
        c = csc(1'b0, 1'b0, 1'b0, 1'b0, 2'h1);
        ahb(1'b1, ADDR_CSC, c);
        set_pin(1'b0);
        set_pin(1'b1);
        check("ie off", 32'h0, chan_irq);
        rchk(ADDR_CSC, c | 32'h80, "poll flag");
        $display("test clear done");
        // counter modes: compare released, compare toggle, edge pwm, center pwm
        ahb(1'b1, ADDR_MODULO, 32'h20);
        rng = xs(rng);
        v = {27'h0, rng[4:0]} + 32'h1;
        ahb(1'b1, ADDR_VALUE, v);
        for (int i = 0; i < 4; i++)
        begin
            m = (i == 0) ? 5'b00100 : (i == 1) ? 5'b00101 : (i == 2) ? 5'b01010 : 5'b11010;
            ahb(1'b1, ADDR_CTRL, {30'h0, 1'b1, m[4]});
            c = csc(1'b0, 1'b0, m[3], m[2], m[1:0]);
            ahb(1'b1, ADDR_CSC, c);
            clear_flag(c);
            t = toggles;
            repeat (2)
            begin
                poll_flag;
                check("match flag", 32'h1, rd[7]);
                ahb(1'b1, ADDR_CSC, c);
            end
            check("drive oe", {31'h0, m[1:0] != 2'h0}, ch_pin_oe);
            if (i == 1)
                check("toggled", 32'h1, toggles > t);
        end
        ahb(1'b1, ADDR_CTRL, 32'h0);
        rchk(ADDR_CTRL, 32'h0, "ctrl off");
        rchk(ADDR_IRQ_STATUS, 32'h3, "wrap status");
        // stopped counter, channel left in edge pwm with high-true polarity
        ahb(1'b0, ADDR_COUNT, 32'h0);
        t = rd;
        check("count range", 32'h1, rd <= 32'h20);
        check("pwm high", pwm_exp(rd[15:0], v[15:0], 1'b0), ch_pin_out);
        ahb(1'b1, ADDR_CSC, c | 32'h4);
        rchk(ADDR_COUNT, t, "count held");
        check("pwm low", pwm_exp(t[15:0], v[15:0], 1'b1), ch_pin_out);
        $display("test modes done");
        close_out;
    end
endmodule
`default_nettype wire
